// ### verification/core_irq_model.sv
// Core and interrupt logic beside the sequencer.
// Assumes the bench pulses go and raise for one cycle.
module core_irq_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic raise,
  input wire logic stop_active,
  output logic stop_req,
  output logic wake_irq
);
  // Stop asked only while running; wake held until stop ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_req <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      stop_req <= go && !stop_active;
      wake_irq <= raise || (wake_irq && stop_active);
    end
  end
endmodule : core_irq_model

// ### verification/stop_wake_chk.sv
// Checker on the wake-up sequencer ports.
// Assumes one pclk domain and presetn active low.
module stop_wake_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic stop_req,
  input wire logic wake_irq,
  input wire logic ext_reset,
  input wire logic osc_clock_fail,
  input wire logic stop_active,
  input wire logic core_clock_enable,
  input wire logic oscillator_enable,
  input wire logic voltage_regulator_enable,
  input wire logic pll_clock_select,
  input wire logic clock_monitor_reset,
  input wire logic reset_gen_start,
  input wire logic core_wake
);
  logic ps;
  logic calm;
  // Plain pseudo-stop: oscillator on, regulator off
  assign ps = stop_active && oscillator_enable && !voltage_regulator_enable;
  assign calm = !ext_reset && !osc_clock_fail;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("pready late");
  chk_stop_entry: assert property (stop_req && !stop_active && !ext_reset
    |=> stop_active && !core_clock_enable) else $error("no stop");
  chk_pll_cleared: assert property (stop_req && !stop_active |=> !pll_clock_select)
    else $error("pll select kept");
  chk_wake_run: assert property (core_wake |-> core_clock_enable && !stop_active)
    else $error("wake not run");
  chk_cm_pair: assert property (clock_monitor_reset |-> reset_gen_start)
    else $error("cm reset alone");
  chk_full_deaf: assert property (
    stop_active && !oscillator_enable && !wake_irq && !ext_reset
    |=> stop_active && !core_wake && !clock_monitor_reset) else $error("full stop left");
  chk_ps_wake: assert property (ps && wake_irq && calm |=> core_wake && !stop_active)
    else $error("no wake");
  chk_ps_hold: assert property (ps && !wake_irq && calm |=> stop_active)
    else $error("stray exit");
endmodule : stop_wake_chk

// ### verification/testbench.sv
// Bench for the stop-mode wake-up sequencer.
// Assumes checker and core model compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import stop_wake_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, err, stop_req, wake_irq, go = 0, raise = 0;
  logic ext_reset = 0, osc_clock_fail = 0, osc_quality_good = 1;
  logic irq, stop_active, core_clock_enable, oscillator_enable, pll_enable;
  logic voltage_regulator_enable, self_clocked_operation, pll_clock_select;
  logic reset_gen_start, clock_monitor_reset, core_wake;
  int fail_count = 0, tests_run = 0, n, cyc;
  localparam int WIN = CHECK_WINDOW_CYCLES * MAX_CHECK_WINDOWS;
  // Register rows: address, write data, read value, write flag, error
  localparam logic [7:0] RA [6] = '{STATE_OFS, CTRL_OFS, STATUS_OFS, MASK_OFS, CTRL_OFS, 8'h10};
  localparam logic [7:0] RD [6] = '{8'h00, 8'h00, 8'h07, 8'h07, 8'h1f, 8'hff};
  localparam logic [7:0] RX [6] = '{8'h01, 8'h03, 8'h00, 8'h07, 8'h1f, 8'h00};
  localparam logic [5:0] RW = 6'b11_1100;
  localparam logic [5:0] RE = 6'b10_0000;
  stop_mode_wakeup_sequencer i_dut (.*);
  core_irq_model i_model (.*);
  always #2.5 pclk = ~pclk;
  task ck(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task step(input int k);
    repeat (k) @(posedge pclk);
  endtask : step
  // One APB transfer, held until pready
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Look at pready mid-cycle, where it has settled
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rdat = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Set control, then let the core ask for stop
  task enter(input logic [7:0] c);
    xfer(CTRL_OFS, 1'b1, c);
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    step(3);
  endtask : enter
  task wake;
    @(posedge pclk);
    raise <= 1'b1;
    @(posedge pclk);
    raise <= 1'b0;
  endtask : wake
  task pulse_rst;
    @(posedge pclk);
    ext_reset <= 1'b1;
    @(posedge pclk);
    ext_reset <= 1'b0;
  endtask : pulse_rst
  // Waits for a wake or reset-generator pulse
  task wait_exit(input int lim);
    cyc = 0;
    while (core_wake !== 1'b1 && reset_gen_start !== 1'b1 && cyc < lim) begin
      @(negedge pclk);
      cyc++;
    end
  endtask : wait_exit
  task fail_for(input int k);
    osc_clock_fail <= 1'b1;
    step(k);
    osc_clock_fail <= 1'b0;
    step(2);
  endtask : fail_for
  task stop_test;
    $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  initial begin
    #200us;
    fail_count++;
    stop_test;
  end
  initial begin
    step(5);
    presetn <= 1'b1;
    step(1);
    ck(core_clock_enable, 1'b1);
    for (int i = 0; i < 6; i++) begin
      if (RW[i]) xfer(RA[i], 1'b1, RD[i]);
      xfer(RA[i], 1'b0, 8'h00);
      ck(rdat, {24'h00_0000, RX[i]});
      ck(err, RE[i]);
    end
    // Pseudo-stop left by a plain wake, then irq mask and clear
    enter(8'h19);
    ck(oscillator_enable, 1'b1);
    ck(pll_clock_select, 1'b0);
    wake;
    wait_exit(20);
    ck(core_wake, 1'b1);
    step(1);
    ck(irq, 1'b1);
    xfer(MASK_OFS, 1'b1, 8'h00);
    step(1);
    ck(irq, 1'b0);
    xfer(MASK_OFS, 1'b1, 8'h07);
    xfer(STATUS_OFS, 1'b1, 8'h07);
    step(1);
    ck(irq, 1'b0);
    xfer(CTRL_OFS, 1'b1, 8'h19);
    step(1);
    ck(pll_clock_select, 1'b1);
    // Clock loss with self-clock irq enabled wakes
    osc_quality_good <= 1'b0;
    enter(8'h0f);
    osc_clock_fail <= 1'b1;
    wait_exit(20);
    osc_clock_fail <= 1'b0;
    ck(core_wake, 1'b1);
    step(1);
    ck(self_clocked_operation, 1'b1);
    // Masked clock loss keeps the core stopped; flag cleared first
    enter(8'h0b);
    xfer(STATUS_OFS, 1'b1, 8'h07);
    fail_for(4);
    ck(stop_active, 1'b1);
    ck({self_clocked_operation, pll_enable, voltage_regulator_enable}, 3'h7);
    xfer(STATUS_OFS, 1'b0, 8'h00);
    ck(rdat[0], 1'b1);
    wake;
    wait_exit(20);
    step(1);
    ck(self_clocked_operation, 1'b1);
    osc_quality_good <= 1'b1;
    step(2 * CHECK_WINDOW_CYCLES + 4);
    ck(self_clocked_operation, 1'b0);
    // Loss with self-clocking off gives monitor reset
    enter(8'h09);
    osc_clock_fail <= 1'b1;
    wait_exit(20);
    osc_clock_fail <= 1'b0;
    ck(clock_monitor_reset, 1'b1);
    xfer(CTRL_OFS, 1'b0, 8'h00);
    ck(rdat, 32'h0000_0003);
    // Monitor off: loss ignored
    enter(8'h08);
    fail_for(4);
    ck({stop_active, self_clocked_operation}, 2'b10);
    wake;
    wait_exit(20);
    // External reset in pseudo-stop
    enter(8'h1c);
    pulse_rst;
    wait_exit(20);
    ck({reset_gen_start, clock_monitor_reset}, 2'b10);
    xfer(CTRL_OFS, 1'b0, 8'h00);
    ck(rdat, 32'h0000_0003);
    // Full stop: monitor deaf, good clock releases quickly
    enter(8'h03);
    ck(oscillator_enable, 1'b0);
    fail_for(4);
    ck(stop_active, 1'b1);
    wake;
    wait_exit(WIN + 200);
    ck(core_wake, 1'b1);
    ck(cyc < CHECK_WINDOW_CYCLES + 20, 1'b1);
    // External reset in full stop
    enter(8'h14);
    pulse_rst;
    wait_exit(WIN + 200);
    ck({reset_gen_start, clock_monitor_reset}, 2'b10);
    // Every window fails, with and without self-clocking
    for (int s = 0; s < 2; s++) begin
      osc_quality_good <= 1'b0;
      enter(s ? 8'h03 : 8'h01);
      wake;
      wait_exit(WIN + 200);
      ck(cyc > WIN - CHECK_WINDOW_CYCLES, 1'b1);
      ck(clock_monitor_reset, s ? 1'b0 : 1'b1);
      step(1);
      if (s) ck(self_clocked_operation, 1'b1);
      osc_quality_good <= 1'b1;
      step(2 * CHECK_WINDOW_CYCLES + 4);
    end
    stop_test;
  end
endmodule : testbench
bind stop_mode_wakeup_sequencer stop_wake_chk i_chk (.*);

// ### verilog/check_window_timer.sv
// Counts out one clock check window and pulses at its end.
// Assumes the quality checker's window length is given as a parameter.
module check_window_timer #(
  parameter int WINDOW_CYCLES = 64,
  parameter int CNT_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic window_end
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic end_ff;
  logic nxt_end;

  // Count while running, restart when stopped
  always_comb begin
    nxt_cnt = '0;
    nxt_end = 1'b0;
    if (run) begin
      if (cnt_ff == CNT_W'(WINDOW_CYCLES - 1)) begin
        nxt_end = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      end_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      end_ff <= nxt_end;
    end
  end

  assign window_end = end_ff;

endmodule : check_window_timer

// ### verilog/stop_mode_wakeup_sequencer.sv
// Stop-mode wake-up sequencer: pseudo-stop and full-stop exit handling.
// Assumes core, interrupt logic and quality checker share pclk; inputs synchronous.
//
// What this block does
// - Pseudo-stop ends only on external reset, clock failure, or wake-up interrupt.
// - External reset in pseudo-stop restores defaults and starts the reset generator.
// - Clock loss, monitor on, self-clocking off: clock monitor reset, distinct vector.
// - Clock loss with self-clocking and its irq enabled: flag, self-clock, wake.
// - Self-clock irq disabled: flag still sets, processor stays in pseudo-stop.
// - Self-clocking keeps regulator and PLL on, checks repeat through pseudo-stop.
// - Later wake or reset exits on PLL self-clock; checks run until oscillator good.
// - Monitor disabled: clock loss in pseudo-stop is ignored.
// - Any other wake interrupt resumes normal operation at once.
// - Every stop exit clears PLL select; software sets it again.
// - Full stop wakes only on external interrupt or external reset.
// - Reset in full stop: defaults, up to 50 check windows, then reset generator.
// - Interrupt wake from full stop: up to 50 windows, pass releases clocks.
// - All windows fail: self-clock if enabled, else clock monitor reset.
// - Clock monitor is inactive during full stop.
// - Pseudo-stop select keeps oscillator running in stop; clear means full stop.
// - Full stop aborts running checks; a full timeout check starts at exit.
module stop_mode_wakeup_sequencer
  import stop_wake_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_req,
  input wire logic wake_irq,
  input wire logic ext_reset,
  input wire logic osc_clock_fail,
  input wire logic osc_quality_good,
  output logic irq,
  output logic stop_active,
  output logic core_clock_enable,
  output logic oscillator_enable,
  output logic pll_enable,
  output logic voltage_regulator_enable,
  output logic self_clocked_operation,
  output logic pll_clock_select,
  output logic reset_gen_start,
  output logic clock_monitor_reset,
  output logic core_wake
);
  import stop_wake_pkg::*;

  // Register state
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [ST_W-1:0] status_ff, nxt_status;
  logic [ST_W-1:0] mask_ff, nxt_mask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic irq_ff, nxt_irq;

  // Sequencer state
  seq_state_t state_ff, nxt_state;
  logic check_rst_ff, nxt_check_rst;
  logic [WIN_CNT_W-1:0] win_ff, nxt_win;
  logic scm_ff, nxt_scm;
  logic stop_ff, nxt_stop;
  logic clk_en_ff, nxt_clk_en;
  logic osc_en_ff, nxt_osc_en;
  logic pll_en_ff, nxt_pll_en;
  logic voltage_regulator_en_ff, nxt_voltage_regulator_en;
  logic rst_start_ff, nxt_rst_start;
  logic cm_rst_ff, nxt_cm_rst;
  logic wake_ff, nxt_wake;

  // Events raised by the sequencer toward the register file
  logic ev_scm_flag, ev_wake, ev_cm_rst, clr_pll_clock_select, restore_defaults;
  logic window_end, timer_run;
  logic wr_en, mapped;

  logic mon_en, self_en, self_irq_en, pseudo_sel;
  assign mon_en = ctrl_ff[CTRL_MON_EN_BIT];
  assign self_en = ctrl_ff[CTRL_SELF_EN_BIT];
  assign self_irq_en = ctrl_ff[CTRL_SELF_IRQ_EN_BIT];
  assign pseudo_sel = ctrl_ff[CTRL_PSEUDO_BIT];

  // Window timer runs in exit checks and in self-clocking outside full stop
  assign timer_run = (state_ff == ST_CHECK) || (scm_ff && (state_ff != ST_FSTOP));

  check_window_timer #(
    .WINDOW_CYCLES(CHECK_WINDOW_CYCLES),
    .CNT_W(7)
  ) u_window (
    .pclk(pclk),
    .presetn(presetn),
    .run(timer_run),
    .window_end(window_end)
  );

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_check_rst = check_rst_ff;
    nxt_win = win_ff;
    nxt_scm = scm_ff;
    nxt_rst_start = 1'b0;
    nxt_cm_rst = 1'b0;
    nxt_wake = 1'b0;
    ev_scm_flag = 1'b0;
    ev_wake = 1'b0;
    ev_cm_rst = 1'b0;
    clr_pll_clock_select = 1'b0;
    restore_defaults = 1'b0;
    // Continuous self-clock checking ends at the first good window
    if (scm_ff && window_end && osc_quality_good && (state_ff != ST_CHECK)) begin
      nxt_scm = 1'b0;
    end
    unique case (state_ff)
      ST_RUN: begin
        if (ext_reset) begin
          restore_defaults = 1'b1;
        end else if (stop_req) begin
          clr_pll_clock_select = 1'b1;
          nxt_state = pseudo_sel ? ST_PSTOP : ST_FSTOP;
        end
      end
      ST_PSTOP: begin
        if (ext_reset) begin
          restore_defaults = 1'b1;
          nxt_rst_start = 1'b1;
          nxt_wake = 1'b1;
          clr_pll_clock_select = 1'b1;
          nxt_state = ST_RUN;
        end else if (mon_en && osc_clock_fail) begin
          if (!self_en) begin
            nxt_cm_rst = 1'b1;
            nxt_rst_start = 1'b1;
            ev_cm_rst = 1'b1;
            restore_defaults = 1'b1;
            nxt_wake = 1'b1;
            clr_pll_clock_select = 1'b1;
            nxt_state = ST_RUN;
          end else begin
            ev_scm_flag = 1'b1;
            nxt_scm = 1'b1;
            if (self_irq_en) begin
              nxt_wake = 1'b1;
              ev_wake = 1'b1;
              clr_pll_clock_select = 1'b1;
              nxt_state = ST_RUN;
            end
          end
        end else if (wake_irq) begin
          nxt_wake = 1'b1;
          ev_wake = 1'b1;
          clr_pll_clock_select = 1'b1;
          nxt_state = ST_RUN;
        end
        // Loss with monitor off falls through with no action
      end
      ST_FSTOP: begin
        // Clock monitor input is not looked at here
        nxt_scm = 1'b0;
        if (ext_reset) begin
          restore_defaults = 1'b1;
          nxt_check_rst = 1'b1;
          nxt_win = '0;
          nxt_state = ST_CHECK;
        end else if (wake_irq) begin
          nxt_check_rst = 1'b0;
          nxt_win = '0;
          nxt_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (window_end) begin
          if (osc_quality_good) begin
            nxt_rst_start = check_rst_ff;
            nxt_wake = 1'b1;
            ev_wake = 1'b1;
            clr_pll_clock_select = 1'b1;
            nxt_state = ST_RUN;
          end else if (win_ff == WIN_CNT_W'(MAX_CHECK_WINDOWS - 1)) begin
            clr_pll_clock_select = 1'b1;
            nxt_wake = 1'b1;
            nxt_state = ST_RUN;
            if (self_en) begin
              nxt_scm = 1'b1;
              nxt_rst_start = check_rst_ff;
              ev_wake = 1'b1;
            end else begin
              nxt_cm_rst = 1'b1;
              nxt_rst_start = 1'b1;
              ev_cm_rst = 1'b1;
              restore_defaults = 1'b1;
            end
          end else begin
            nxt_win = win_ff + WIN_CNT_W'(1);
          end
        end
      end
    endcase
  end

  // Clock and power controls derived from the next state
  always_comb begin
    nxt_stop = (nxt_state != ST_RUN);
    nxt_clk_en = (nxt_state == ST_RUN);
    nxt_osc_en = (nxt_state != ST_FSTOP);
    nxt_pll_en = nxt_scm || pll_clock_select_next();
    nxt_voltage_regulator_en = (nxt_state != ST_FSTOP) && (nxt_state != ST_PSTOP || nxt_scm);
  end

  function automatic logic pll_clock_select_next();
    pll_clock_select_next = nxt_ctrl[CTRL_PLL_SEL_BIT];
  endfunction : pll_clock_select_next

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_RUN;
      check_rst_ff <= 1'b0;
      win_ff <= '0;
      scm_ff <= 1'b0;
      stop_ff <= 1'b0;
      clk_en_ff <= 1'b1;
      osc_en_ff <= 1'b1;
      pll_en_ff <= 1'b0;
      voltage_regulator_en_ff <= 1'b1;
      rst_start_ff <= 1'b0;
      cm_rst_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      check_rst_ff <= nxt_check_rst;
      win_ff <= nxt_win;
      scm_ff <= nxt_scm;
      stop_ff <= nxt_stop;
      clk_en_ff <= nxt_clk_en;
      osc_en_ff <= nxt_osc_en;
      pll_en_ff <= nxt_pll_en;
      voltage_regulator_en_ff <= nxt_voltage_regulator_en;
      rst_start_ff <= nxt_rst_start;
      cm_rst_ff <= nxt_cm_rst;
      wake_ff <= nxt_wake;
    end
  end

  // APB decode: zero-wait answer in the first access cycle
  assign wr_en = psel && penable && pready_ff && pwrite;
  assign mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) ||
                  (paddr == MASK_OFS) || (paddr == STATE_OFS);

  // Register file next values
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    nxt_pready = psel && !penable;
    nxt_pslverr = psel && !penable && !mapped;
    nxt_prdata = prdata_ff;
    if (psel && !penable) begin
      unique case (paddr)
        CTRL_OFS: nxt_prdata = {27'h000_0000, ctrl_ff};
        STATUS_OFS: nxt_prdata = {29'h0000_0000, status_ff};
        MASK_OFS: nxt_prdata = {29'h0000_0000, mask_ff};
        STATE_OFS: nxt_prdata = {26'h000_0000, scm_ff, stop_ff, state_ff};
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        CTRL_OFS: nxt_ctrl = pwdata[CTRL_W-1:0];
        STATUS_OFS: nxt_status = status_ff & ~pwdata[ST_W-1:0];
        MASK_OFS: nxt_mask = pwdata[ST_W-1:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    // Hardware events win over software writes
    if (clr_pll_clock_select) begin
      nxt_ctrl[CTRL_PLL_SEL_BIT] = 1'b0;
    end
    if (restore_defaults) begin
      nxt_ctrl = CTRL_RESET;
    end
    nxt_status[ST_SELF_FLAG_BIT] = nxt_status[ST_SELF_FLAG_BIT] | ev_scm_flag;
    nxt_status[ST_WAKE_BIT] = nxt_status[ST_WAKE_BIT] | ev_wake;
    nxt_status[ST_CMRST_BIT] = nxt_status[ST_CMRST_BIT] | ev_cm_rst;
    nxt_irq = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      status_ff <= ST_RESET;
      mask_ff <= MASK_RESET;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff <= nxt_irq;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign stop_active = stop_ff;
  assign core_clock_enable = clk_en_ff;
  assign oscillator_enable = osc_en_ff;
  assign pll_enable = pll_en_ff;
  assign voltage_regulator_enable = voltage_regulator_en_ff;
  assign self_clocked_operation = scm_ff;
  assign pll_clock_select = ctrl_ff[CTRL_PLL_SEL_BIT];
  assign reset_gen_start = rst_start_ff;
  assign clock_monitor_reset = cm_rst_ff;
  assign core_wake = wake_ff;

endmodule : stop_mode_wakeup_sequencer

// ### verilog/stop_wake_pkg.sv
// Shared constants for the stop-mode wake-up sequencer.
// Assumes a single 200 MHz APB clock domain.
package stop_wake_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0c;

  // Control register field positions
  localparam int CTRL_MON_EN_BIT = 0;
  localparam int CTRL_SELF_EN_BIT = 1;
  localparam int CTRL_SELF_IRQ_EN_BIT = 2;
  localparam int CTRL_PSEUDO_BIT = 3;
  localparam int CTRL_PLL_SEL_BIT = 4;
  localparam int CTRL_W = 5;

  // Control defaults: monitor on, self-clocking allowed, irq off, full stop
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h03;

  // Status and mask field positions
  localparam int ST_SELF_FLAG_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_CMRST_BIT = 2;
  localparam int ST_W = 3;
  localparam logic [ST_W-1:0] ST_RESET = 3'h0;
  localparam logic [ST_W-1:0] MASK_RESET = 3'h0;

  // Clock check windows
  localparam int CHECK_WINDOW_CYCLES = 64;
  localparam int MAX_CHECK_WINDOWS = 50;
  localparam int WIN_CNT_W = 6;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_PSTOP = 4'b0010,
    ST_FSTOP = 4'b0100,
    ST_CHECK = 4'b1000
  } seq_state_t;

endpackage : stop_wake_pkg
